// ===== dbs_map.svh
// Constants for the DMA bus bandwidth sharing block
`ifndef DBS_MAP_SVH
`define DBS_MAP_SVH
`define DBS_NUM_CH      3
`define DBS_NUM_REQ     8
`define DBS_SEL_W       3
`define DBS_SHARE_W     2
`define DBS_GAP_W       3
`define DBS_GAP_25      3'h6
`define DBS_GAP_50      3'h2
`define DBS_GAP_67      3'h1
`define DBS_GAP_100     3'h1
`define DBS_SHARE_25    2'h0
`define DBS_SHARE_50    2'h1
`define DBS_SHARE_67    2'h2
`define DBS_SHARE_100   2'h3
`define DBS_NO_CH       2'h3
`endif

// ===== dbs_pkg.sv
// Types for the DMA bus bandwidth sharing block
package dbs_pkg;
	typedef enum logic [4:0] {
		DBS_IDLE = 5'b00001,
		DBS_HIGH = 5'b00010,
		DBS_LOW  = 5'b00100,
		DBS_GAP  = 5'b01000,
		DBS_CPU  = 5'b10000
	} dbs_state_e;
endpackage

// ===== dbs_irq_rank.sv
// Fixed priority ranking of CPU interrupt sources against DMA
`timescale 1ns/1ps
`include "dbs_map.svh"
module dbs_irq_rank
	import dbs_pkg::*;
(
	// Interrupt sources
	input  wire logic       swi_req,
	input  wire logic       ext_req,
	input  wire logic       tim_req,
	input  wire logic       spi_req,
	input  wire logic       sci_req,
	// DMA side
	input  wire logic       dma_pend,
	input  wire logic       dma_priority_select,
	// Result
	output logic [4:0]      irq_grant,
	output logic            dma_wins
);
	logic any_irq;
	always_comb
	begin
		irq_grant = 5'h00;
		// RL4: fixed source order
		if (swi_req)
			irq_grant = 5'h01;
		else if (ext_req)
			irq_grant = 5'h02;
		else if (tim_req)
			irq_grant = 5'h04;
		else if (spi_req)
			irq_grant = 5'h08;
		else if (sci_req)
			irq_grant = 5'h10;
	end
	assign any_irq = |irq_grant;
	// RL3: rank DMA by select bit
	assign dma_wins = dma_pend && (dma_priority_select || !any_irq);
endmodule

// ===== dbs_core.sv
// DMA request routing, word sequencing and CPU gap insertion
//
// Function
// RL1: Select value 111 routes request input 7, serial transmit, to the channel.
// RL2: Three-bit select per channel picks one of eight request inputs.
// RL3: DMA priority select bit puts DMA above or below CPU interrupts.
// RL4: Interrupt order: software, external, timer, SPI, SCI.
// RL5: Word transfers always take full bandwidth regardless of share field; the code still inserts share-sized gaps between looped word blocks.
// RL6: No CPU cycles between word bytes nor between words of a block.
// RL7: Insert CPU cycles on channel change and between looped blocks.
// RL8: Share 00 gives six CPU cycles, share 01 gives two.
// RL9: Share 10 and 11 each give one CPU cycle.
// RL10: Bus returns to CPU only after last byte write completes.
`timescale 1ns/1ps
`include "dbs_map.svh"
module dbs_core
	import dbs_pkg::*;
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// Peripheral service requests (pins, asynchronous)
	input  wire logic [7:0] svc_req,
	// Channel configuration
	input  wire logic [2:0] request_source_select [3],
	input  wire logic [2:0] ch_enable,
	input  wire logic [2:0] ch_word,
	input  wire logic [2:0] ch_loop,
	input  wire logic       bandwidth_share_high,
	input  wire logic       bandwidth_share_low,
	input  wire logic       dma_priority_select,
	// CPU interrupt sources
	input  wire logic       swi_req,
	input  wire logic       ext_req,
	input  wire logic       tim_req,
	input  wire logic       spi_req,
	input  wire logic       sci_req,
	// Bus transfer handshake
	input  wire logic       xfer_done,
	input  wire logic       block_last,
	// Status
	output logic            dma_bus_own,
	output logic [1:0]      active_ch,
	output logic            byte_high,
	output logic            cpu_gap,
	output logic [4:0]      irq_grant
);
	////////////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [7:0] sync1;
		logic [7:0] sync2;
		dbs_state_e st;
		logic [1:0] ch;
		logic [1:0] last_ch;
		logic [2:0] gap_cnt;
	} dbs_core_s;
	dbs_core_s cur_ff;
	dbs_core_s nxt_ff;
	logic [2:0] ch_req;
	logic [1:0] pick;
	logic       dma_pend;
	logic       dma_wins;
	logic [1:0] share;

	// RL8: gap length lookup
	// RL9: one cycle shares
	function automatic logic [2:0] gap_len(input logic [1:0] s);
		case (s)
			`DBS_SHARE_25:  gap_len = `DBS_GAP_25;
			`DBS_SHARE_50:  gap_len = `DBS_GAP_50;
			`DBS_SHARE_67:  gap_len = `DBS_GAP_67;
			default:        gap_len = `DBS_GAP_100;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	assign share = {bandwidth_share_high, bandwidth_share_low};
	// RL2: route selected source per channel
	// RL1: select 111 reaches input 7
	always_comb
	begin
		for (int i = 0; i < `DBS_NUM_CH; i++)
			ch_req[i] = ch_enable[i] & cur_ff.sync2[request_source_select[i]];
	end
	// Lowest channel number wins when several are pending
	always_comb
	begin
		pick = 2'h0;
		if (ch_req[0])
			pick = 2'h0;
		else if (ch_req[1])
			pick = 2'h1;
		else
			pick = 2'h2;
	end
	assign dma_pend = |ch_req;

	dbs_irq_rank u_rank (
		.swi_req            (swi_req),
		.ext_req            (ext_req),
		.tim_req            (tim_req),
		.spi_req            (spi_req),
		.sci_req            (sci_req),
		.dma_pend           (dma_pend),
		.dma_priority_select(dma_priority_select),
		.irq_grant          (irq_grant),
		.dma_wins           (dma_wins)
	);

	////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		nxt_ff = cur_ff;
		nxt_ff.sync1 = svc_req;
		nxt_ff.sync2 = cur_ff.sync1;
		case (cur_ff.st)
			DBS_IDLE:
			begin
				if (dma_wins)
				begin
					nxt_ff.ch = pick;
					// RL7: gap on channel change
					if (cur_ff.last_ch != `DBS_NO_CH && cur_ff.last_ch != pick)
					begin
						nxt_ff.gap_cnt = gap_len(share);
						nxt_ff.st = DBS_GAP;
					end
					else
						nxt_ff.st = DBS_HIGH;
				end
			end
			DBS_GAP:
			begin
				// CPU owns the bus while the gap runs down
				if (cur_ff.gap_cnt <= 3'h1)
					nxt_ff.st = DBS_HIGH;
				else
					nxt_ff.gap_cnt = cur_ff.gap_cnt - 3'h1;
			end
			DBS_HIGH:
			begin
				if (xfer_done)
				begin
					// RL6: low byte follows with no CPU slot
					if (ch_word[cur_ff.ch])
						nxt_ff.st = DBS_LOW;
					else
						nxt_ff.st = DBS_CPU;
				end
			end
			DBS_LOW:
			begin
				if (xfer_done)
				begin
					// RL5: full bandwidth, words chain back to back
					if (!block_last)
						nxt_ff.st = DBS_HIGH;
					else
						nxt_ff.st = DBS_CPU;
				end
			end
			DBS_CPU:
			begin
				// RL10: release only after final write
				nxt_ff.last_ch = cur_ff.ch;
				// RL7: looped block gets a gap before restart
				if (block_last && ch_loop[cur_ff.ch])
				begin
					nxt_ff.gap_cnt = gap_len(share);
					nxt_ff.st = DBS_GAP;
				end
				else
					nxt_ff.st = DBS_IDLE;
			end
			default:
				nxt_ff.st = DBS_IDLE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cur_ff.sync1    <= 8'h00;
			cur_ff.sync2    <= 8'h00;
			cur_ff.st       <= DBS_IDLE;
			cur_ff.ch       <= 2'h0;
			cur_ff.last_ch  <= `DBS_NO_CH;
			cur_ff.gap_cnt  <= 3'h0;
		end
		else
			cur_ff <= nxt_ff;
	end

	////////////////////////////////////////////////////////////////////////
	assign dma_bus_own = cur_ff.st == DBS_HIGH || cur_ff.st == DBS_LOW;
	assign active_ch   = cur_ff.ch;
	assign byte_high   = cur_ff.st == DBS_HIGH;
	assign cpu_gap     = cur_ff.st == DBS_GAP;

	////////////////////////////////////////////////////////////////////////
	sequence s_word_mid;
		cur_ff.st == DBS_HIGH && xfer_done && ch_word[cur_ff.ch];
	endsequence

	a_word_atomic: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL6
		s_word_mid |=> dma_bus_own)
		else $error("CPU slot inside word");
	a_word_chain: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL5
		(cur_ff.st == DBS_LOW && xfer_done && !block_last) |=> byte_high)
		else $error("Words of block not chained");
	a_gap_six: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL8
		($rose(cpu_gap) && share == 2'h0) |-> cpu_gap [*6] ##1 !cpu_gap)
		else $error("Share 00 gap not six cycles");
	a_gap_two: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL8
		($rose(cpu_gap) && share == 2'h1) |-> cpu_gap [*2] ##1 !cpu_gap)
		else $error("Share 01 gap not two cycles");
	a_gap_one: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL9
		($rose(cpu_gap) && share[1]) |=> !cpu_gap)
		else $error("Share 1x gap not one cycle");
	a_ch_change: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL7
		(cur_ff.st == DBS_IDLE && dma_wins && cur_ff.last_ch != `DBS_NO_CH
		 && cur_ff.last_ch != pick) |=> cpu_gap)
		else $error("No gap on channel change");
	a_release_last: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL10
		$fell(dma_bus_own) |-> $past(xfer_done))
		else $error("Bus released before final write");
	a_src_seven: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL1
		(ch_enable[0] && request_source_select[0] == 3'h7 && cur_ff.sync2[7])
		|-> ch_req[0])
		else $error("Input 7 not routed");
	a_dma_rank: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL3
		(cur_ff.st == DBS_IDLE && dma_pend && !dma_priority_select && |irq_grant)
		|=> !dma_bus_own && !cpu_gap)
		else $error("DMA ran above interrupt");
endmodule

// ===== dbs_bus_model.sv
// Bus partner that completes DMA byte writes
`timescale 1ns/1ps
module dbs_bus_model
(
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst_n,
	// Bus side
	input  wire logic       dma_bus_own,
	input  wire logic [1:0] wait_n,
	input  wire logic [2:0] blk_len,
	output logic            xfer_done,
	output logic            block_last
);
	logic [1:0] wcnt_ff;
	logic [2:0] bcnt_ff;
	logic       fin;
	// Count holds into the release cycle, where the loop decision reads the last flag
	assign block_last = (bcnt_ff >= blk_len - 3'h1);
	// No extra pulse in the release cycle
	assign fin = xfer_done & block_last;
	always_ff @(posedge sys_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			xfer_done <= 1'b0;
			wcnt_ff   <= 2'h0;
			bcnt_ff   <= 3'h0;
		end
		else
		begin
			xfer_done <= dma_bus_own & !fin & (wcnt_ff == wait_n);
			wcnt_ff   <= (dma_bus_own & !fin & (wcnt_ff != wait_n)) ? wcnt_ff + 2'h1 : 2'h0;
			bcnt_ff   <= !dma_bus_own ? 3'h0 : bcnt_ff + {2'h0, xfer_done};
		end
	end
endmodule

// ===== dma_bus_bandwidth_sharing_test.sv
// Self-checking bench for the DMA bus sharing core
`timescale 1ns/1ps
module dma_bus_bandwidth_sharing_test;
	logic       sys_clk, rst_n, dma_priority_select, sh, sl, xfer_done, block_last;
	logic       swi_req, ext_req, tim_req, spi_req, sci_req, dma_bus_own, byte_high, cpu_gap;
	logic [7:0] svc_req;
	logic [2:0] rss [3];
	logic [2:0] ch_enable, ch_word, ch_loop, blk_len, s;
	logic [1:0] wait_n, active_ch, last_ch, c;
	logic [4:0] irq_grant, v;
	int         num_errors, n_checks, cyc;
	dbs_core u_dut (.sys_clk(sys_clk), .rst_n(rst_n), .svc_req(svc_req),
		.request_source_select(rss), .ch_enable(ch_enable), .ch_word(ch_word),
		.ch_loop(ch_loop), .bandwidth_share_high(sh), .bandwidth_share_low(sl),
		.dma_priority_select(dma_priority_select), .swi_req(swi_req), .ext_req(ext_req),
		.tim_req(tim_req), .spi_req(spi_req), .sci_req(sci_req), .xfer_done(xfer_done),
		.block_last(block_last), .dma_bus_own(dma_bus_own), .active_ch(active_ch),
		.byte_high(byte_high), .cpu_gap(cpu_gap), .irq_grant(irq_grant));
	dbs_bus_model u_bus (.sys_clk(sys_clk), .rst_n(rst_n), .dma_bus_own(dma_bus_own),
		.wait_n(wait_n), .blk_len(blk_len), .xfer_done(xfer_done), .block_last(block_last));
	task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			num_errors++;
			$display("[ERR] %s expected %0h seen %0h", nm, e, g);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	function automatic logic [7:0] exp_gap(input logic [1:0] sh2, input logic chg);
		exp_gap = !chg ? 8'h0 : (sh2 == 2'h0) ? 8'h6 : (sh2 == 2'h1) ? 8'h2 : 8'h1;
	endfunction
	// Gap cycles seen until the DMA takes the bus
	task automatic count_gap(output logic [7:0] g);
		g = 8'h0;
		for (int i = 0; i < 40 && !dma_bus_own; i++)
		begin
			g = g + 8'(cpu_gap);
			@(negedge sys_clk);
		end
	endtask
	// Byte completions seen while the DMA holds the bus
	task automatic count_bytes(output logic [7:0] d);
		d = 8'h0;
		for (int i = 0; i < 60 && dma_bus_own; i++)
		begin
			d = d + 8'(xfer_done);
			@(negedge sys_clk);
		end
	endtask
	// One block on channel ch from request input src, looped once when lp is set
	task automatic xfer(input logic [1:0] ch, input logic [2:0] src, input logic wd,
		input logic lp);
		logic [7:0] g, d;
		logic [2:0] n;
		n = wd ? 3'h2 << ($urandom % 2) : 3'h1;
		@(negedge sys_clk);
		ch_word[ch] = wd;
		ch_loop[ch] = lp;
		blk_len = n;
		wait_n = 2'($urandom);
		svc_req[src] = 1'b1;
		count_gap(g);
		svc_req[src] = 1'b0;
		check("own_ch", {5'h1, ch, 1'b1}, {4'h0, dma_bus_own, active_ch, byte_high}); // routing
		check("gap", exp_gap({sh, sl}, last_ch != 2'h3 && ch != last_ch), g); // gap size
		count_bytes(d);
		check("bytes", {5'h0, n}, d); // whole block held
		if (lp)
		begin
			count_gap(g);
			ch_loop[ch] = 1'b0;
			check("loop_gap", exp_gap({sh, sl}, 1'b1), g); // looped restart gap
			count_bytes(d);
			check("loop_bytes", {5'h0, n}, d); // looped block held
		end
		last_ch = ch;
		repeat (2) @(negedge sys_clk);
	endtask
	initial
	begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			num_errors++;
			wrap_up;
		end
	end
	initial
	begin
		void'($urandom(32'h6666));
		{rst_n, dma_priority_select, sh, sl, svc_req, ch_word, ch_loop, wait_n} = '0;
		{swi_req, ext_req, tim_req, spi_req, sci_req} = 5'h0;
		rss = '{3'h0, 3'h1, 3'h2};
		ch_enable = 3'h7;
		blk_len = 3'h1;
		last_ch = 2'h3;
		repeat (8) @(negedge sys_clk);
		check("rst", 8'h0, {4'h0, dma_bus_own, cpu_gap, active_ch});
		rst_n = 1'b1;
		repeat (16)
		begin
			@(negedge sys_clk);
			v = 5'($urandom);
			{sci_req, spi_req, tim_req, ext_req, swi_req} = v;
			#1 check("irq", {3'h0, v & (~v + 5'h1)}, {3'h0, irq_grant}); // fixed order
		end
		{sci_req, spi_req, tim_req, ext_req, swi_req} = 5'h4;
		svc_req[0] = 1'b1;
		repeat (20)
		begin
			@(negedge sys_clk);
			check("refused", 8'h0, {7'h0, dma_bus_own}); // DMA below CPU
		end
		dma_priority_select = 1'b1;
		xfer(2'h0, 3'h0, 1'b0, 1'b0); // DMA above CPU
		tim_req = 1'b0;
		for (int i = 0; i < 32; i++)
		begin
			s = 3'(i);
			// Source 7 on channel 0 forced once as a corner case
			c = (i == 7) ? 2'h0 : 2'((last_ch + $urandom % 3) % 3);
			{sh, sl} = 2'(i);
			for (int k = 0; k < 3; k++)
				rss[k] = s + 3'(k + 8 - c);
			xfer(c, s, 1'($urandom), 1'($urandom)); // mixed traffic
		end
		wrap_up;
	end
endmodule
